// *** hdl/smdi_pkg.sv ***
// Shared constants and types for the switch input controller and its host.
// Assumes both ends run on one 40 MHz reference clock.
`default_nettype none
package smdi_pkg;
	// Input bank layout
	localparam int NUM_IN  = 22;
	localparam int NUM_SP  = 8;
	localparam int SEL_W   = 5;
	localparam int FRAME   = 24;
	localparam int FRAME2  = 48;
	localparam int BCNT_W  = 6;
	localparam int OP_HI   = 23;
	localparam int OP_LO   = 16;
	localparam int PULL_LO = 5;
	// Command opcodes, frame bits 23:16
	localparam logic [7:0] OP_STATUS   = 8'h00;
	localparam logic [7:0] OP_SETTINGS = 8'h01;
	localparam logic [7:0] OP_TMR_SP   = 8'h02;
	localparam logic [7:0] OP_TMR_SG   = 8'h03;
	localparam logic [7:0] OP_TRI_SP   = 8'h04;
	localparam logic [7:0] OP_TRI_SG   = 8'h05;
	localparam logic [7:0] OP_MET_SP   = 8'h06;
	localparam logic [7:0] OP_MET_SG   = 8'h07;
	localparam logic [7:0] OP_ANALOG   = 8'h08;
	localparam logic [7:0] OP_SLEEP    = 8'h0C;
	// Analog pull-up codes
	localparam logic [1:0] PULL_HIZ  = 2'h0;
	localparam logic [1:0] PULL_2MA  = 2'h1;
	localparam logic [1:0] PULL_16MA = 2'h2;
	// Reset values
	localparam logic [SEL_W-1:0] RST_SEL = 5'h1F;
	localparam logic             RST_TRI = 1'b1;
	localparam logic             RST_TMR = 1'b1;
	localparam logic             RST_MET = 1'b0;
	localparam logic             RST_TYP = 1'b0;
	// Timing
	localparam int CLK_KHZ  = 40000;
	localparam int WET_MS   = 20;
	localparam int WET_CYC  = WET_MS * CLK_KHZ;
	localparam int WET_W    = 20;
	localparam int HALF_NS  = 100;
	localparam int HALF_CYC = HALF_NS * CLK_KHZ / 1000000;
	localparam int DIV_W    = 4;
	// Host register map
	localparam logic [7:0] REG_CMD  = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_RX   = 8'h0C;
	typedef enum logic {MODE_NORMAL, MODE_SLEEP} smdi_mode_type;
	typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP}
		smdi_hstate_type;
endpackage
`default_nettype wire

// *** hdl/smdi_link_if.sv ***
// Serial link between host and switch input controller.
// Assumes the bench joins the ends; no clock of its own.
`timescale 1ns/1ps
`default_nettype none
interface smdi_link_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so;
	logic so_oe;
	logic so_pin;
	// Serial out line level, low while undriven
	assign so_pin = so_oe ? so : 1'b0;
	modport dev (input cs_n, input sclk, input si, output so, output so_oe);
	modport host (output cs_n, output sclk, output si, input so_pin);
endinterface
`default_nettype wire

// *** hdl/smdi_sync.sv ***
// Two flip-flop synchroniser for one bit.
// Assumes the input is asynchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module smdi_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic ref_clk_i,
	input  wire logic resetn_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_r;

	// Two stages, first read only by second
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			meta_r <= RST_VAL;
			q_o    <= RST_VAL;
		end
		else
		begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule
`default_nettype wire

// *** hdl/smdi_device.sv ***
// Switch input controller: command decode, drive control, analog routing.
// Assumes link pins, comparator levels and supply flag are asynchronous.
//
// Contract
// R1: Route one of 22 inputs on frame end.
// R2: Selected input reads zero in status.
// R3: Analog input: hi-Z, 2 mA or 16 mA.
// R4: Reset: Normal mode, all inputs tri-stated.
// R5: Programmable inputs can source or sink.
// R6: Host orders timer, level, type, tri-state.
// R7: Metallic command sets 16 or 2 mA.
// R8: Battery type, tri-state off: sink current.
// R9: Ground type sources, battery type sinks.
// R10: Ground input tri-state off enables pull-up.
// R11: Host disables timer, sets 16 mA first.
// R12: Comparator reports pin while tri-stated.
// R13: Ground input at 2 mA crossing: interrupt.
// R14: Chip-select fall with supply wakes device.
// R15: No wake without logic supply.
// R16: Parallel devices get separate chip selects.
// R17: Chaining devices serially is recommended.
// R18: Two chained devices take 48 clocks.
// R19: Sleep entered on frame-ending chip-select rise.
// R20: Supply-enable low in Normal, high asleep.
// R21: High current only first 20 ms closed.
// R22: Analog selection holds until changed.
// R23: Settings update only on latched frame.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module smdi_device #(
	parameter int unsigned WET_CYCLES = smdi_pkg::WET_CYC
) (
	input  wire logic                          ref_clk_i,
	input  wire logic                          resetn_i,
	smdi_link_if.dev                           link,
	input  wire logic [smdi_pkg::NUM_IN-1:0]   pin_low_i,
	input  wire logic                          vdd_present_i,
	output logic      [smdi_pkg::NUM_IN-1:0]   source_en_o,
	output logic      [smdi_pkg::NUM_IN-1:0]   sink_en_o,
	output logic      [smdi_pkg::NUM_IN-1:0]   high_cur_o,
	output logic      [smdi_pkg::SEL_W-1:0]    analog_route_out_sel_o,
	output logic      [1:0]                    analog_route_out_pull_o,
	output logic                               int_n_o,
	output logic                               wake_n_o
);
	import smdi_pkg::*;

	localparam int SYNC_W = NUM_IN + 4;
	localparam logic [WET_W-1:0] WET_LIM = WET_W'(WET_CYCLES);

	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] syn;
	logic [NUM_IN-1:0] pin_s;
	logic              cs_s;
	logic              sclk_s;
	logic              si_s;
	logic              vdd_s;
	logic              cs_q_r;
	logic              sclk_q_r;
	logic              cs_fall;
	logic              cs_rise;
	logic              sclk_rise;
	logic              active_r;
	logic [FRAME-1:0]  sh_r;
	logic [BCNT_W-1:0] bcnt_r;
	logic              latch;
	logic [7:0]        op;
	logic [15:0]       dat;
	smdi_mode_type     mode_r;
	logic [SEL_W-1:0]  sel_r;
	logic [1:0]        pull_r;
	logic [NUM_IN-1:0] tri_r;
	logic [NUM_IN-1:0] tmr_r;
	logic [NUM_IN-1:0] met_r;
	logic [NUM_IN-1:0] typ_r;
	logic [NUM_IN-1:0] sel_hit;
	logic [NUM_IN-1:0] src_nxt;
	logic [NUM_IN-1:0] snk_nxt;
	logic [NUM_IN-1:0] hi_nxt;
	logic [NUM_IN-1:0] pin_q_r;
	logic [NUM_IN-1:0] int_elig;
	logic              int_set;
	logic              int_r;
	logic [WET_W-1:0]  wet_r [NUM_IN];

	//------------------------------------------------------------
	// Input synchronisers
	//------------------------------------------------------------
	assign raw = {vdd_present_i, link.si, link.sclk, link.cs_n, pin_low_i};

	for (genvar s = 0; s < SYNC_W; s++)
	begin : g_sync
		smdi_sync #(
			.RST_VAL(logic'(s == NUM_IN))
		) u_sync (
			.ref_clk_i(ref_clk_i),
			.resetn_i (resetn_i),
			.d_i      (raw[s]),
			.q_o      (syn[s])
		);
	end

	assign pin_s  = syn[NUM_IN-1:0];
	assign cs_s   = syn[NUM_IN];
	assign sclk_s = syn[NUM_IN+1];
	assign si_s   = syn[NUM_IN+2];
	assign vdd_s  = syn[NUM_IN+3];

	//------------------------------------------------------------
	// Frame control
	//------------------------------------------------------------
	// Edge history of chip select and clock
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cs_q_r   <= 1'b1;
			sclk_q_r <= 1'b0;
		end
		else
		begin
			cs_q_r   <= cs_s;
			sclk_q_r <= sclk_s;
		end
	end

	assign cs_fall   = cs_q_r & ~cs_s;
	assign cs_rise   = ~cs_q_r & cs_s;
	assign sclk_rise = ~sclk_q_r & sclk_s & active_r;
	// Whole frames only: 24 bits, or 48 when chained
	assign latch = cs_rise & active_r
		& (bcnt_r == BCNT_W'(FRAME) | bcnt_r == BCNT_W'(FRAME2)); // R23
	assign op  = sh_r[OP_HI:OP_LO];
	assign dat = sh_r[15:0];

	// Frame open only while awake
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			active_r <= 1'b0;
		else if (cs_rise)
			active_r <= 1'b0;
		else if (cs_fall && mode_r == MODE_NORMAL)
			active_r <= 1'b1;
	end

	// Status load, then shift in on each clock rise
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sh_r   <= '0;
			bcnt_r <= '0;
		end
		else if (cs_fall && mode_r == MODE_NORMAL)
		begin
			sh_r   <= {1'b0, int_r, pin_s & ~sel_hit}; // R2 R12
			bcnt_r <= '0;
		end
		else if (sclk_rise)
		begin
			sh_r <= {sh_r[FRAME-2:0], si_s};
			if (bcnt_r != '1)
				bcnt_r <= bcnt_r + 1'b1;
		end
	end

	assign link.so    = sh_r[FRAME-1];
	assign link.so_oe = active_r;

	//------------------------------------------------------------
	// Mode
	//------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			mode_r <= MODE_NORMAL; // R4
		else if (mode_r == MODE_SLEEP && cs_fall && vdd_s)
			mode_r <= MODE_NORMAL; // R14 R15
		else if (latch && op == OP_SLEEP)
			mode_r <= MODE_SLEEP; // R19
	end

	// Supply enable follows mode
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			wake_n_o <= 1'b0;
		else
			wake_n_o <= (mode_r == MODE_SLEEP); // R20
	end

	//------------------------------------------------------------
	// Analog routing
	//------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sel_r  <= RST_SEL;
			pull_r <= PULL_HIZ;
		end
		else if (latch && op == OP_ANALOG)
		begin
			sel_r  <= dat[SEL_W-1:0]; // R1 R22
			pull_r <= dat[PULL_LO+1:PULL_LO]; // R3
		end
	end

	assign analog_route_out_sel_o  = sel_r;
	assign analog_route_out_pull_o = pull_r;

	//------------------------------------------------------------
	// Per input configuration and drive
	//------------------------------------------------------------
	for (genvar i = 0; i < NUM_IN; i++)
	begin : g_in
		localparam bit IS_SP = (i < NUM_SP);
		localparam int FI = IS_SP ? i : i - NUM_SP;
		localparam logic [7:0] OT = IS_SP ? OP_TRI_SP : OP_TRI_SG;
		localparam logic [7:0] OM = IS_SP ? OP_MET_SP : OP_MET_SG;
		localparam logic [7:0] OW = IS_SP ? OP_TMR_SP : OP_TMR_SG;
		logic closed;
		logic hot;

		// Configuration bits, frame end only
		always_ff @(posedge ref_clk_i or negedge resetn_i)
		begin
			if (!resetn_i)
			begin
				tri_r[i] <= RST_TRI; // R4
				tmr_r[i] <= RST_TMR;
				met_r[i] <= RST_MET;
				typ_r[i] <= RST_TYP;
			end
			else if (latch)
			begin
				if (op == OT)
					tri_r[i] <= dat[FI]; // R23
				if (op == OW)
					tmr_r[i] <= dat[FI];
				if (op == OM)
					met_r[i] <= dat[FI]; // R7
				if (IS_SP && op == OP_SETTINGS)
					typ_r[i] <= dat[FI]; // R5
			end
		end

		assign closed = typ_r[i] ? ~pin_s[i] : pin_s[i];

		// Time since switch closure
		always_ff @(posedge ref_clk_i or negedge resetn_i)
		begin
			if (!resetn_i)
				wet_r[i] <= '0;
			else if (!closed)
				wet_r[i] <= '0;
			else if (wet_r[i] != WET_LIM)
				wet_r[i] <= wet_r[i] + 1'b1;
		end

		assign hot = met_r[i] & (~tmr_r[i] | wet_r[i] != WET_LIM); // R21
		assign sel_hit[i] = (sel_r == SEL_W'(i));

		// Source, sink and level per input
		always_comb
		begin
			src_nxt[i] = 1'b0;
			snk_nxt[i] = 1'b0;
			hi_nxt[i]  = 1'b0;
			if (mode_r == MODE_SLEEP)
				src_nxt[i] = 1'b0;
			else if (sel_hit[i])
			begin
				src_nxt[i] = (pull_r != PULL_HIZ); // R3
				hi_nxt[i]  = (pull_r == PULL_16MA);
			end
			else if (!tri_r[i])
			begin
				snk_nxt[i] = typ_r[i]; // R8 R9
				src_nxt[i] = ~typ_r[i]; // R9 R10
				hi_nxt[i]  = hot; // R7
			end
		end

		assign int_elig[i] = !IS_SP && source_en_o[i] && !high_cur_o[i];
	end

	// Registered drive outputs
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			source_en_o <= '0;
			sink_en_o   <= '0;
			high_cur_o  <= '0;
		end
		else
		begin
			source_en_o <= src_nxt;
			sink_en_o   <= snk_nxt;
			high_cur_o  <= hi_nxt;
		end
	end

	//------------------------------------------------------------
	// Interrupt
	//------------------------------------------------------------
	assign int_set = |((pin_s ^ pin_q_r) & int_elig); // R13

	// Sticky flag, set beats frame-end clear
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_q_r <= '0;
			int_r   <= 1'b0;
		end
		else
		begin
			pin_q_r <= pin_s;
			if (int_set)
				int_r <= 1'b1;
			else if (cs_rise && active_r)
				int_r <= 1'b0;
		end
	end

	assign int_n_o = ~int_r;
endmodule
`default_nettype wire

// *** hdl/smdi_host.sv ***
// Host end: software registers drive command frames over the link.
// Assumes a plain register port on the same clock as the link logic.
`timescale 1ns/1ps
`default_nettype none
module smdi_host (
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	smdi_link_if.host        link,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o
);
	import smdi_pkg::*;

	smdi_hstate_type   st_r;
	logic [DIV_W-1:0]  div_r;
	logic [BCNT_W-1:0] bit_r;
	logic [FRAME-1:0]  tx_r;
	logic [FRAME-1:0]  rx_r;
	logic              chain_r;
	logic              cs_r;
	logic              sclk_r;
	logic              so_s;
	logic              tick;
	logic              start;
	logic              last;

	//------------------------------------------------------------
	// Link input
	//------------------------------------------------------------
	smdi_sync #(
		.RST_VAL(1'b0)
	) u_so_sync (
		.ref_clk_i(ref_clk_i),
		.resetn_i (resetn_i),
		.d_i      (link.so_pin),
		.q_o      (so_s)
	);

	assign tick  = (div_r == DIV_W'(HALF_CYC - 1))
		|| (st_r == H_GAP && div_r == DIV_W'(2 * HALF_CYC - 1));
	assign start = wr_i && addr_i == REG_CMD && st_r == H_IDLE;
	// Chain sends the frame twice in one select
	assign last = bit_r == (chain_r ? BCNT_W'(FRAME2 - 1)
		: BCNT_W'(FRAME - 1)); // R18 R17

	//------------------------------------------------------------
	// Frame sequencer
	//------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_r  <= H_IDLE;
			div_r <= '0;
			bit_r <= '0;
		end
		else
		begin
			div_r <= (st_r == H_IDLE || tick) ? '0 : div_r + 1'b1;
			unique case (st_r)
				H_IDLE:
					if (start)
					begin
						st_r  <= H_LOW;
						bit_r <= '0;
					end
				H_LOW:
					if (tick)
						st_r <= H_HIGH;
				H_HIGH:
					if (tick)
					begin
						st_r  <= last ? H_TAIL : H_LOW;
						bit_r <= bit_r + 1'b1;
					end
				H_TAIL:
					if (tick)
						st_r <= H_GAP;
				H_GAP:
					if (tick)
						st_r <= H_IDLE;
			endcase
		end
	end

	// Pin levels: one select per frame
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cs_r   <= 1'b1;
			sclk_r <= 1'b0;
		end
		else
		begin
			if (start)
				cs_r <= 1'b0; // R16
			else if (st_r == H_TAIL && tick)
				cs_r <= 1'b1;
			if (st_r == H_LOW && tick)
				sclk_r <= 1'b1;
			else if (st_r == H_HIGH && tick)
				sclk_r <= 1'b0;
		end
	end

	assign link.cs_n = cs_r;
	assign link.sclk = sclk_r;
	assign link.si   = tx_r[FRAME-1];

	// Transmit rotates, receive samples at end of high phase
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tx_r <= '0;
			rx_r <= '0;
		end
		else if (start)
			tx_r <= wdata_i[FRAME-1:0];
		else if (st_r == H_HIGH && tick)
		begin
			tx_r <= {tx_r[FRAME-2:0], tx_r[FRAME-1]};
			rx_r <= {rx_r[FRAME-2:0], so_s};
		end
	end

	//------------------------------------------------------------
	// Software registers
	//------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			chain_r <= 1'b0;
		else if (wr_i && addr_i == REG_CTRL)
			chain_r <= wdata_i[0];
	end

	// Read data one cycle after strobe
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_o <= '0;
		else if (rd_i)
			unique case (addr_i)
				REG_CTRL: rdata_o <= {31'h0000_0000, chain_r};
				REG_STAT: rdata_o <= {31'h0000_0000, st_r != H_IDLE};
				REG_RX:   rdata_o <= {8'h00, rx_r};
				default:  rdata_o <= '0;
			endcase
		else
			rdata_o <= '0;
	end
endmodule
`default_nettype wire

// *** testbench/smdi_checker.sv ***
// Link checker: framing, clock shape and data-out enable on the link.
// Assumes the link signals are sampled on the shared reference clock.
`timescale 1ns/1ps
`default_nettype none
module smdi_checker
	import smdi_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic resetn_i,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic si,
	input  wire logic so_oe
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic [6:0] rise_cnt_r;
	logic       sclk_d_r;

	// Previous link clock level
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			sclk_d_r <= 1'h0;
		else
			sclk_d_r <= sclk;
	end

	// Link clock rises within one selection
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rise_cnt_r <= 7'h00;
		else if (cs_n)
			rise_cnt_r <= 7'h00;
		else if (sclk && !sclk_d_r)
			rise_cnt_r <= rise_cnt_r + 7'h01;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	frame_len_a: assert property (
		$rose(cs_n) |-> (rise_cnt_r == FRAME || rise_cnt_r == FRAME2))
		else $error("frame closed after a wrong clock count");
	sclk_high_a: assert property (
		$rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("link clock high phase not four cycles");
	sclk_low_a: assert property (
		$fell(sclk) |-> !sclk [*4])
		else $error("link clock low phase too short");
	sclk_idle_a: assert property (
		cs_n |-> !sclk)
		else $error("link clock moving outside a frame");
	cs_gap_a: assert property (
		$rose(cs_n) |-> cs_n [*3])
		else $error("chip select gap too short");
	si_hold_a: assert property (
		(!cs_n && sclk) |-> $stable(si))
		else $error("host data changed while clock high");
	oe_off_a: assert property (
		cs_n [*6] |-> !so_oe)
		else $error("device drives data out of frame");
	oe_on_a: assert property (
		$rose(so_oe) |-> !cs_n && !$past(cs_n, 2))
		else $error("device opened frame without chip select");
	reset_idle_a: assert property (
		$rose(resetn_i) |-> cs_n && !sclk && !so_oe)
		else $error("link not idle after reset");
endmodule
`default_nettype wire

// *** testbench/switch_input_mux_and_drive_control_tb.sv ***
// Bench: host registers drive command frames into the device over the link.
// Assumes package, interface, both ends and the checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module switch_input_mux_and_drive_control_tb;
	import smdi_pkg::*;
	localparam int WET   = 50;
	localparam int LIMIT = 20000;
	logic              ref_clk_i, resetn_i, wr_i, rd_i, vdd_present_i;
	logic              int_n_o, wake_n_o;
	logic [1:0]        pull_o;
	logic [SEL_W-1:0]  sel_o;
	logic [7:0]        addr_i;
	logic [31:0]       wdata_i, rdata_o, rx;
	logic [NUM_IN-1:0] pin_low_i, source_en_o, sink_en_o, high_cur_o;
	int                error_cnt = 0;
	int                samples_checked = 0;
	int                cycles = 0;
	smdi_link_if link ();

	// Both ends and the link checker
	smdi_device #(.WET_CYCLES(WET)) smdi_device_inst (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link.dev),
		.pin_low_i(pin_low_i), .vdd_present_i(vdd_present_i),
		.source_en_o(source_en_o), .sink_en_o(sink_en_o),
		.high_cur_o(high_cur_o), .analog_route_out_sel_o(sel_o),
		.analog_route_out_pull_o(pull_o), .int_n_o(int_n_o),
		.wake_n_o(wake_n_o));
	smdi_host smdi_host_inst (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link.host),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o));
	smdi_checker smdi_checker_inst (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cs_n(link.cs_n),
		.sclk(link.sclk), .si(link.si), .so_oe(link.so_oe));

	// ----------------------------------------------------------------
	// Clock, timeout and tasks
	// ----------------------------------------------------------------
	// 40 MHz reference clock
	initial
	begin
		ref_clk_i = 1'h0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// Cut a hang short
	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			error_cnt++;
			conclude();
		end
	end

	task automatic conclude();
		if (error_cnt == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string n, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", n, exp, seen);
		end
	endtask

	// One-cycle write, then one idle edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge ref_clk_i);
		wr_i <= 1'h0;
		@(posedge ref_clk_i);
	endtask

	// One-cycle read, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge ref_clk_i);
		rd_i <= 1'h0;
		@(posedge ref_clk_i);
		d = rdata_o;
	endtask

	// Poll busy until the frame is over
	task automatic idle();
		int n;
		n = 0;
		rx = 32'h0000_0001;
		while (rx[0] !== 1'h0 && n < 600)
		begin
			rd(REG_STAT, rx);
			n++;
		end
		check("busy", rx[0], 1'h0);
		repeat (4) @(posedge ref_clk_i);
	endtask

	task automatic cmd(input logic [23:0] f);
		wr(REG_CMD, {8'h00, f});
		idle();
	endtask

	task automatic status();
		cmd({OP_STATUS, 16'h0000});
		rd(REG_RX, rx);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		static logic [4:0] sels [3] = '{5'h00, 5'h0a, 5'h15};
		static logic [1:0] pulls [3] = '{PULL_HIZ, PULL_2MA, PULL_16MA};
		logic [21:0] mask;
		resetn_i = 1'h0;
		wr_i = 1'h0;
		rd_i = 1'h0;
		addr_i = 8'h00;
		wdata_i = 32'h0000_0000;
		pin_low_i = '0;
		vdd_present_i = 1'h1;
		repeat (4) @(posedge ref_clk_i);
		resetn_i <= 1'h1;
		repeat (4) @(posedge ref_clk_i);
		// Reset state and an unmapped read
		check("source", source_en_o, 1'h0);
		check("sink", sink_en_o, 1'h0);
		check("sel", sel_o, RST_SEL);
		check("pull", pull_o, PULL_HIZ);
		check("wake", wake_n_o, 1'h0);
		check("int", int_n_o, 1'h1);
		rd(8'h10, rx);
		check("unmapped", rx, 1'h0);
		// Tri-stated ground input pulled low
		pin_low_i[8] <= 1'h1;
		status();
		check("status", rx[23:0], 24'h00_0100);
		// Programmable input as drive output
		cmd({OP_TMR_SP, 16'h0000});
		cmd({OP_MET_SP, 16'h0001});
		cmd({OP_SETTINGS, 16'h0001});
		wr(REG_CMD, {8'h00, OP_TRI_SP, 16'h00fe});
		repeat (100) @(posedge ref_clk_i);
		check("sink mid", sink_en_o[0], 1'h0);
		idle();
		check("sink", sink_en_o[0], 1'h1);
		check("source", source_en_o[0], 1'h0);
		check("level", high_cur_o[0], 1'h1);
		cmd({OP_SETTINGS, 16'h0000});
		check("source", source_en_o[0], 1'h1);
		check("sink", sink_en_o[0], 1'h0);
		cmd({OP_SETTINGS, 16'h0001});
		check("sink", sink_en_o[0], 1'h1);
		cmd({OP_MET_SP, 16'h0000});
		check("level", high_cur_o[0], 1'h0);
		// Ground input toggled by tri-state
		cmd({OP_TMR_SG, 16'h0000});
		cmd({OP_MET_SG, 16'h0001});
		cmd({OP_TRI_SG, 16'h3ffe});
		check("source", source_en_o[8], 1'h1);
		check("level", high_cur_o[8], 1'h1);
		cmd({OP_TRI_SG, 16'h3fff});
		check("source", source_en_o[8], 1'h0);
		// Wetting timer on a closing ground input
		cmd({OP_TMR_SG, 16'h0002});
		cmd({OP_MET_SG, 16'h0002});
		cmd({OP_TRI_SG, 16'h3ffd});
		pin_low_i[9] <= 1'h1;
		repeat (10) @(posedge ref_clk_i);
		check("wet on", high_cur_o[9], 1'h1);
		repeat (WET) @(posedge ref_clk_i);
		check("wet off", high_cur_o[9], 1'h0);
		// Interrupt from a 2 mA ground input
		cmd({OP_TRI_SG, 16'h3ff9});
		check("int", int_n_o, 1'h1);
		pin_low_i[10] <= 1'h1;
		repeat (8) @(posedge ref_clk_i);
		check("int", int_n_o, 1'h0);
		status();
		check("int flag", rx[22], 1'h1);
		check("int", int_n_o, 1'h1);
		// Analog routing, every pull code
		pin_low_i <= '1;
		for (int i = 0; i < 3; i++)
		begin
			cmd({OP_ANALOG, 9'h000, pulls[i], sels[i]});
			check("sel", sel_o, sels[i]);
			check("pull", pull_o, pulls[i]);
			status();
			mask = ~(22'h00_0001 << sels[i]);
			check("status", rx[21:0], mask);
		end
		cmd({OP_MET_SP, 16'h0000});
		check("sel", sel_o, 5'h15);
		// Chained 48-clock frame
		wr(REG_CTRL, 32'h0000_0001);
		cmd({OP_ANALOG, 16'h0003});
		check("sel", sel_o, 5'h03);
		wr(REG_CTRL, 32'h0000_0000);
		// Sleep and wake by chip select
		cmd({OP_SLEEP, 16'h0038});
		check("wake", wake_n_o, 1'h1);
		check("source", source_en_o, 1'h0);
		vdd_present_i <= 1'h0;
		repeat (4) @(posedge ref_clk_i);
		status();
		check("wake", wake_n_o, 1'h1);
		vdd_present_i <= 1'h1;
		repeat (4) @(posedge ref_clk_i);
		status();
		check("wake", wake_n_o, 1'h0);
		conclude();
	end
endmodule
`default_nettype wire
